// *** verilog/port_regs_defs.svh ***
`ifndef PORT_REGS_DEFS_SVH
`define PORT_REGS_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PORT_SELECT_ADDR      8'h4c
`define PARITY_HIGH_ADDR      8'h55
`define PARITY_LOW_ADDR       8'h56
`define SELFTEST_TALLY_ADDR   8'h57
`define REVERSE_CFG_ADDR      8'h58

// ----------------------------------------------------------------------
// Reverse channel config fields
// ----------------------------------------------------------------------
`define CFG_PASS_ALL_BIT      7
`define CFG_PASS_MATCH_BIT    6
`define CFG_AUTO_ACK_BIT      5
`define CFG_FORCE_ON_BIT      4
`define CFG_CRC_GEN_BIT       3
`define CFG_RATE_MSB          2
`define CFG_RATE_LSB          0

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define CFG_RESET_HIGH        5'h03
`define COUNT_RESET           16'h0000
`define NUM_PORTS             4
`define PORT_SEL_RESET        8'h00

`endif

// *** verilog/port_regs_pkg.sv ***
package port_regs_pkg;

  typedef enum logic [2:0] {
    RATE_2P5M  = 3'h0,
    RATE_RSV1  = 3'h1,
    RATE_10M   = 3'h2,
    RATE_RSV3  = 3'h3,
    RATE_RSV4  = 3'h4,
    RATE_RSV5  = 3'h5,
    RATE_50M   = 3'h6,
    RATE_RSV7  = 3'h7
  } rate_code_t;

  typedef struct packed {
    logic       pass_all;
    logic       pass_match;
    logic       auto_ack;
    logic       force_on;
    logic       crc_gen_en;
    rate_code_t rate_sel;
  } reverse_cfg_t;

  typedef struct packed {
    logic       write;
    logic       read;
    logic       from_link;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_t;

  typedef struct packed {
    logic       channel_en;
    logic       crc_gen_en;
    logic       pass_all;
    logic       pass_match;
    logic       auto_ack;
    logic       rate_valid;
    rate_code_t rate_sel;
  } channel_ctrl_t;

endpackage

// *** verilog/pin_sync.sv ***
`timescale 1ns/1ps

module pin_sync (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // Pin in, synchronised out
  input  wire logic i_pin,
  output logic      o_level
);

  logic meta_q;
  logic sync_q;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= i_pin;
      sync_q <= meta_q;
    end
  end

  assign o_level = sync_q;

endmodule // pin_sync

// *** verilog/parity_counter.sv ***
`timescale 1ns/1ps
`include "port_regs_defs.svh"

module parity_counter (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // Events
  input  wire logic        i_parity_err,
  input  wire logic        i_lock_valid,
  input  wire logic        i_low_read,
  // Count
  output logic [15:0]      o_count
);

  logic [15:0] count_q;
  logic [15:0] count_d;
  wire         restart = i_lock_valid | i_low_read;
  wire         at_max  = &count_q;

  // Error in the clearing cycle starts the new count at one
  assign count_d = restart ? {15'h0000, i_parity_err}
                 : (i_parity_err && !at_max) ? count_q + 16'h0001
                 : count_q;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count_q <= `COUNT_RESET;
    end else begin
      count_q <= count_d;
    end
  end

  assign o_count = count_q;

endmodule // parity_counter

// *** verilog/port_link_errors_and_backchannel_cfg.sv ***
// How it works
// - Port-select register picks which port copy
// - Count parity errors since lock or read
// - Low count read returns then clears, if any port is selected
// - Read-only self-test error tally per port
// - Pass-all bit forwards every I2C transaction
// - Match bit forwards address-matched transactions only
// - Auto-ack bit acknowledges all writes locally
// - Force-on keeps channel on, else forwarding
// - Force-on writable only from local master
// - CRC generation follows enable bit
// - Rate field resets from sampled strap
// - Rate codes 000 2.5M, 010 10M
// - Brief errors after rate change tolerated
// - High count byte cleared on low read with a port selected
`timescale 1ns/1ps
`include "port_regs_defs.svh"

module port_link_errors_and_backchannel_cfg (
  // Clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_resetn,
  // Register access
  input  wire port_regs_pkg::reg_access_t    i_access,
  output logic [7:0]                         o_rdata,
  // Strap pins
  input  wire logic [2:0]                    i_rate_strap,
  // Per-port link events
  input  wire logic [`NUM_PORTS-1:0]         i_parity_err,
  input  wire logic [`NUM_PORTS-1:0]         i_lock_valid,
  input  wire logic [`NUM_PORTS*8-1:0]       i_selftest_errs,
  // Per-port reverse channel control
  input  wire logic [`NUM_PORTS-1:0]         i_addr_match,
  output port_regs_pkg::channel_ctrl_t [`NUM_PORTS-1:0] o_ctrl
);

  // --------------------------------------------------------------------
  // Strap capture
  // --------------------------------------------------------------------
  logic [2:0] strap_sync;
  logic       strap_done_q;
  logic [2:0] strap_q;

  genvar s;
  generate
    for (s = 0; s < 3; s = s + 1) begin : g_strap
      pin_sync u_sync (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_pin    (i_rate_strap[s]),
        .o_level  (strap_sync[s])
      );
    end
  endgenerate

  // Strap settles through the synchroniser before being latched
  logic [1:0] strap_wait_q;
  wire        strap_take = !strap_done_q && (strap_wait_q == 2'h3);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      strap_wait_q <= 2'h0;
      strap_done_q <= 1'b0;
      strap_q      <= 3'h0;
    end else begin
      if (strap_wait_q != 2'h3) begin
        strap_wait_q <= strap_wait_q + 2'h1;
      end
      if (strap_take) begin
        strap_done_q <= 1'b1;
        strap_q      <= strap_sync;
      end
    end
  end

  // --------------------------------------------------------------------
  // Port select and decode
  // --------------------------------------------------------------------
  logic [7:0] port_sel_q;

  wire sel_hit   = i_access.addr == `PORT_SELECT_ADDR;
  wire hi_hit    = i_access.addr == `PARITY_HIGH_ADDR;
  wire lo_hit    = i_access.addr == `PARITY_LOW_ADDR;
  wire tally_hit = i_access.addr == `SELFTEST_TALLY_ADDR;
  wire cfg_hit   = i_access.addr == `REVERSE_CFG_ADDR;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      port_sel_q <= `PORT_SEL_RESET;
    end else if (i_access.write && sel_hit) begin
      port_sel_q <= i_access.wdata;
    end
  end

  // One-hot select bits; several set gives a broadcast write
  wire [`NUM_PORTS-1:0] port_en = port_sel_q[`NUM_PORTS-1:0];

  // Reads come from the lowest selected port
  logic [1:0] read_port;
  always_comb begin
    read_port = 2'h0;
    for (int p = `NUM_PORTS - 1; p >= 0; p--) begin
      if (port_en[p]) begin
        read_port = p[1:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // Per-port registers
  // --------------------------------------------------------------------
  logic [15:0]                       count     [`NUM_PORTS];
  port_regs_pkg::reverse_cfg_t       cfg_q     [`NUM_PORTS];
  logic [7:0]                        tally     [`NUM_PORTS];

  genvar g;
  generate
    for (g = 0; g < `NUM_PORTS; g = g + 1) begin : g_port
      wire low_read = i_access.read && lo_hit &&
                      (read_port == 2'(g)) && (port_en != '0);
      wire cfg_wr   = i_access.write && cfg_hit && port_en[g];

      parity_counter u_count (
        .i_clk        (i_clk),
        .i_resetn     (i_resetn),
        .i_parity_err (i_parity_err[g]),
        .i_lock_valid (i_lock_valid[g]),
        .i_low_read   (low_read),
        .o_count      (count[g])
      );

      assign tally[g] = i_selftest_errs[g*8 +: 8];

      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          cfg_q[g].pass_all   <= 1'b0;
          cfg_q[g].pass_match <= 1'b0;
          cfg_q[g].auto_ack   <= 1'b0;
          cfg_q[g].force_on   <= 1'b1;
          cfg_q[g].crc_gen_en <= 1'b1;
          cfg_q[g].rate_sel   <= port_regs_pkg::RATE_2P5M;
        end else if (strap_take) begin
          cfg_q[g].rate_sel <= port_regs_pkg::rate_code_t'(strap_sync);
        end else if (cfg_wr) begin
          cfg_q[g].pass_all   <= i_access.wdata[`CFG_PASS_ALL_BIT];
          cfg_q[g].pass_match <= i_access.wdata[`CFG_PASS_MATCH_BIT];
          cfg_q[g].auto_ack   <= i_access.wdata[`CFG_AUTO_ACK_BIT];
          if (!i_access.from_link) begin
            cfg_q[g].force_on <= i_access.wdata[`CFG_FORCE_ON_BIT];
          end
          cfg_q[g].crc_gen_en <= i_access.wdata[`CFG_CRC_GEN_BIT];
          cfg_q[g].rate_sel   <= port_regs_pkg::rate_code_t'(
            i_access.wdata[`CFG_RATE_MSB:`CFG_RATE_LSB]);
        end
      end

      // Reserved rate codes leave the rate invalid; the channel
      // keeps running so a brief mis-set is not a hard fault
      wire rate_ok = (cfg_q[g].rate_sel == port_regs_pkg::RATE_2P5M) ||
                     (cfg_q[g].rate_sel == port_regs_pkg::RATE_10M)  ||
                     (cfg_q[g].rate_sel == port_regs_pkg::RATE_50M);

      assign o_ctrl[g].channel_en = cfg_q[g].force_on ||
                                    cfg_q[g].pass_all ||
                                    cfg_q[g].pass_match;
      assign o_ctrl[g].crc_gen_en = cfg_q[g].crc_gen_en;
      assign o_ctrl[g].pass_all   = cfg_q[g].pass_all;
      assign o_ctrl[g].pass_match = cfg_q[g].pass_match &&
                                    i_addr_match[g];
      assign o_ctrl[g].auto_ack   = cfg_q[g].auto_ack;
      assign o_ctrl[g].rate_valid = rate_ok;
      assign o_ctrl[g].rate_sel   = cfg_q[g].rate_sel;
    end
  endgenerate

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  port_regs_pkg::reverse_cfg_t rd_cfg;
  assign rd_cfg = cfg_q[read_port];

  wire [7:0] rd_mux =
      sel_hit   ? port_sel_q :
      hi_hit    ? count[read_port][15:8] :
      lo_hit    ? count[read_port][7:0] :
      tally_hit ? tally[read_port] :
      cfg_hit   ? rd_cfg :
                  8'h00;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 8'h00;
    end else if (i_access.read) begin
      o_rdata <= rd_mux;
    end
  end

endmodule // port_link_errors_and_backchannel_cfg

// *** dv/link_event_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Receive link events for four ports
// ----------------------------------------
module link_event_model (
  input  wire logic   i_clk,
  output logic [3:0]  o_par,
  output logic [3:0]  o_lock,
  output logic [31:0] o_tally
);
  initial begin
    o_par = 4'h0;
    o_lock = 4'h0;
    o_tally = 32'h0;
  end
  // Quiet outside bursts, so the host reads a settled count
  task automatic errs(input int p, input int n);
    o_tally[8*p+:8] = 8'($urandom);
    repeat (n) begin
      @(negedge i_clk);
      o_par[p] = 1'b1;
      @(negedge i_clk);
      o_par[p] = 1'b0;
    end
  endtask
  task automatic lock(input int p);
    @(negedge i_clk);
    o_lock[p] = 1'b1;
    @(negedge i_clk);
    o_lock[p] = 1'b0;
  endtask
endmodule // link_event_model

// *** dv/port_regs_sva.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Port 0 view of the register group
// ----------------------------------------
module port_regs_sva (
  input wire logic                         i_clk,
  input wire logic                         i_resetn,
  input wire port_regs_pkg::reg_access_t   i_access,
  input wire logic [7:0]                   o_rdata,
  input wire logic [2:0]                   i_rate_strap,
  input wire logic [3:0]                   i_parity_err,
  input wire logic [3:0]                   i_lock_valid,
  input wire logic [31:0]                  i_selftest_errs,
  input wire logic [3:0]                   i_addr_match,
  input wire port_regs_pkg::channel_ctrl_t [3:0] o_ctrl
);
  logic [3:0] sel_q;
  wire rd = i_access.read;
  wire [7:0] a = i_access.addr;
  wire p0 = sel_q[0] | (sel_q == 4'h0);
  wire rlow = rd && a == 8'h56 && sel_q[0];
  wire wcfg = i_access.write && a == 8'h58 && sel_q[0];
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) sel_q <= 4'h0;
    else if (i_access.write && a == 8'h4c) sel_q <= i_access.wdata[3:0];
  end
  chk_hold_rdata: assert property (!rd |=> $stable(o_rdata))
    else $error("read data moved without a read");
  chk_low_clear: assert property (
    rlow && !i_parity_err[0] ##1 rlow |=> o_rdata == 8'h00)
    else $error("low count not cleared by read");
  chk_high_clear: assert property (
    rlow && !i_parity_err[0] ##1 rd && a == 8'h55 && sel_q[0]
    |=> o_rdata == 8'h00) else $error("high count not cleared");
  chk_tally_read: assert property (
    rd && a == 8'h57 && p0 |=> o_rdata == $past(i_selftest_errs[7:0]))
    else $error("tally read wrong");
  chk_unmapped_zero: assert property (
    rd && !(a inside {8'h4c, [8'h55:8'h58]}) |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_enable_pass: assert property (
    o_ctrl[0].pass_all || o_ctrl[0].pass_match |-> o_ctrl[0].channel_en)
    else $error("forwarding without channel enable");
  chk_rate_valid: assert property (
    o_ctrl[0].rate_valid == (o_ctrl[0].rate_sel inside {3'h0, 3'h2, 3'h6}))
    else $error("rate valid flag wrong");
  chk_cfg_write: assert property (
    wcfg && !i_access.from_link |=> o_ctrl[0].auto_ack ==
    $past(i_access.wdata[5]) && o_ctrl[0].crc_gen_en ==
    $past(i_access.wdata[3])) else $error("config write not applied");
  cov_low_read: cover property (rlow);
  cov_link_write: cover property (wcfg && i_access.from_link);
  cov_fast_rate: cover property (o_ctrl[0].rate_sel == 3'h6);
endmodule // port_regs_sva

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  port_regs_pkg::reg_access_t acc = '0;
  logic [7:0] rdata;
  logic [7:0] d;
  logic [2:0] strap;
  logic [3:0] par, lock, am;
  logic [31:0] tally;
  port_regs_pkg::channel_ctrl_t [3:0] ctrl;
  int fail_count = 0, total_checks = 0, cnt;
  always #10 i_clk = ~i_clk;
  link_event_model i_link_event_model (.i_clk(i_clk), .o_par(par),
    .o_lock(lock), .o_tally(tally));
  port_link_errors_and_backchannel_cfg
    i_port_link_errors_and_backchannel_cfg (.i_clk(i_clk),
    .i_resetn(i_resetn), .i_access(acc), .o_rdata(rdata),
    .i_rate_strap(strap), .i_parity_err(par), .i_lock_valid(lock),
    .i_selftest_errs(tally), .i_addr_match(am), .o_ctrl(ctrl));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Requests stay up across calls so reads can run back to back
  task automatic wr(input logic [7:0] a, dt, input logic lk = 1'b0);
    acc = '{1'b1, 1'b0, lk, a, dt};
    @(negedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a, e);
    acc = '{1'b0, 1'b1, 1'b0, a, 8'h00};
    @(negedge i_clk);
    chk(16'(rdata), 16'(e));
  endtask
  task automatic idle(input int n);
    acc = '0;
    repeat (n) @(negedge i_clk);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(34));
    strap = 3'($urandom);
    am = 4'h0;
    repeat (6) @(negedge i_clk);
    i_resetn = 1'b1;
    idle(8);
    rd(8'h58, 8'h18 | 8'(strap));
    for (int p = 0; p < 4; p++) begin
      wr(8'h4c, 8'(1 << p));
      idle(1);
      cnt = 1 + $urandom % 300;
      i_link_event_model.errs(p, cnt);
      rd(8'h55, 8'(cnt >> 8));
      rd(8'h56, 8'(cnt));
      rd(8'h56, 8'h00);
      rd(8'h55, 8'h00);
      rd(8'h57, tally[8*p+:8]);
      idle(1);
      i_link_event_model.errs(p, 3);
      i_link_event_model.lock(p);
      rd(8'h56, 8'h00);
    end
    $display("parity test done");
    wr(8'h4c, 8'h0f);
    for (int c = 0; c < 8; c++) begin
      d = {5'($urandom), 3'(c)};
      wr(8'h58, d);
      am = 4'($urandom);
      #1;
      for (int p = 0; p < 4; p++)
        chk(16'(ctrl[p]), 16'({d[4] | d[7] | d[6], d[3], d[7], d[6] & am[p],
          d[5], c == 0 || c == 2 || c == 6, 3'(c)}));
      rd(8'h58, d);
    end
    $display("config test done");
    // Auto-ack first, then a rate move; force-on kept set locally
    wr(8'h58, 8'h30);
    wr(8'h58, 8'h36);
    #1;
    chk(16'(ctrl[1].auto_ack), 16'h1);
    chk(16'(ctrl[1].channel_en), 16'h1);
    wr(8'h58, 8'h00, 1'b1);
    rd(8'h58, 8'h10);
    wr(8'h58, 8'h00);
    chk(16'(ctrl[2].channel_en), 16'h0);
    wr(8'h57, 8'hff);
    rd(8'h57, tally[7:0]);
    rd(8'h59, 8'h00);
    rd(8'h4c, 8'h0f);
    idle(2);
    $display("access test done");
    stop_test();
  end
  initial begin
    #400us;
    fail_count++;
    stop_test();
  end
endmodule // tb
bind port_link_errors_and_backchannel_cfg port_regs_sva i_port_regs_sva (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_access(i_access),
  .o_rdata(o_rdata), .i_rate_strap(i_rate_strap),
  .i_parity_err(i_parity_err), .i_lock_valid(i_lock_valid),
  .i_selftest_errs(i_selftest_errs), .i_addr_match(i_addr_match),
  .o_ctrl(o_ctrl));
